// ==== gcp_pkg.sv ====
/*
  Shared constants and types for the gauge command port: the fixed
  target address, the command-space limits, the status location and
  its field, the port state encoding and the write-request carrier.
  Assumes an I2C target with no clock stretching and byte addressing.
*/
package gcp_pkg;

  // Fixed 7-bit target address and the two address bytes it implies
  localparam logic [6:0] GCP_DEV_ADDR = 7'h55;
  localparam logic [7:0] GCP_ADDR_WR = 8'hAA;
  localparam logic [7:0] GCP_ADDR_RD = 8'hAB;

  // Highest command location that may be named
  localparam logic [7:0] GCP_CMD_TOP = 8'h6B;

  // Profile status location and its single defined field
  localparam logic [7:0] GCP_REG_LAST_PROFILE_STATUS = 8'h6A;
  localparam int GCP_LAST_PROFILE_BIT = 0;
  localparam logic GCP_LAST_PROFILE_RST = 1'b0;
  localparam logic [6:0] GCP_STATUS_UNUSED = 7'h00;

  // Byte returned when an incremental read runs past the top location
  localparam logic [7:0] GCP_IDLE_BYTE = 8'hFF;

  // Bit counting within one byte
  localparam logic [3:0] GCP_LAST_BIT = 4'h7;
  localparam logic [3:0] GCP_BYTE_BITS = 4'h8;

  // Byte index within a write transfer: command, first data, extra
  localparam logic [1:0] GCP_IDX_CMD = 2'h0;
  localparam logic [1:0] GCP_IDX_DATA = 2'h1;
  localparam logic [1:0] GCP_IDX_MAX = 2'h3;

  // Port sequencer states, one-hot
  typedef enum logic [6:0] {
    GCP_ST_IDLE = 7'h01,  // Bus free or not yet addressed
    GCP_ST_ADDR = 7'h02,  // Shifting in the address byte
    GCP_ST_RX   = 7'h04,  // Shifting in a command or data byte
    GCP_ST_ACK  = 7'h08,  // Driving our acknowledge
    GCP_ST_TX   = 7'h10,  // Driving a read byte
    GCP_ST_MACK = 7'h20,  // Controller's acknowledge slot
    GCP_ST_WAIT = 7'h40   // Ignoring the bus until start or stop
  } gcp_state_e;

  // Write request handed to the gauge core
  typedef struct packed {
    logic [7:0] addr;  // Command location
    logic [7:0] data;  // Byte written
  } gcp_wr_s;

endpackage

// ==== gcp_link_capture.sv ====
/*
  Serial-clock side of the command port: samples the data line on each
  rising serial clock edge and flags the edge with a toggle.
  Assumes the controller meets data setup to the clock; the core side
  reads the bit only after the toggle has passed its synchroniser.
*/
`timescale 1ns/100ps
module gcp_link_capture (
  input wire logic i_scl_clk,
  input wire logic i_link_rst,
  input wire logic i_sda,
  output logic o_bit,
  output logic o_edge_tgl
);

  logic bit_reg;  // Last sampled data bit
  logic tgl_reg;  // Flips once per rising clock edge

  // Async reset because the serial clock stands still between frames
  always_ff @(posedge i_scl_clk or posedge i_link_rst) begin
    if (i_link_rst) begin
      bit_reg <= 1'b1;
      tgl_reg <= 1'b0;
    end else begin
      bit_reg <= i_sda;
      tgl_reg <= ~tgl_reg;
    end
  end

  assign o_bit = bit_reg;
  assign o_edge_tgl = tgl_reg;

endmodule

// ==== gcp_command_port.sv ====
/*
  Gauge I2C target port, core side: start and stop, address match,
  pointer, acknowledge and read shifting. Assumes no clock stretching
  and a core that answers reads combinationally from o_rd_addr.
  // Operation
  // - Answer only fixed address 1010101
  // - Address bytes are AA write, AB read
  // - Single, incremental, one-byte write, quick read
  // - Quick read returns data at pointer
  // - Pointer advances on every acknowledged data byte
  // - Written bytes use the same incrementing pointer
  // - Read-only location written: NACK, unchanged
  // - Command above 6B is NACKed
  // - Data bytes after the first are NACKed
  // - Location 6A returns last-profile status byte
  // - Last-profile flag resets to first profile
  // - Deep sleep wakes only when addressed
  // - Snooze ends on any addressed activity
*/
`timescale 1ns/100ps
module gcp_command_port
  import gcp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic [7:0] o_rd_addr,
  input wire logic [7:0] i_rd_data,
  input wire logic i_loc_read_only,
  output logic o_wr_stb,
  output gcp_wr_s o_wr_req,
  input wire logic i_profile_upd,
  input wire logic i_profile_second,
  output logic o_last_profile_used_flag,
  input wire logic i_hibernate,
  input wire logic i_snooze,
  output logic o_hib_wake,
  output logic o_snooze_exit
);

  logic link_rst_reg;  // Reset handed to the serial clock domain
  logic cap_bit;  // Bit sampled on the serial clock
  logic cap_tgl;  // Edge toggle from the serial clock
  logic scl_s1_reg, scl_s2_reg, scl_d_reg;  // Clock pin synchroniser
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;  // Data pin synchroniser
  logic tgl_s1_reg, tgl_s2_reg, tgl_d_reg;  // Edge toggle synchroniser
  gcp_state_e st_reg;  // Sequencer state
  logic [3:0] cnt_reg;  // Bits handled in the current byte
  logic [7:0] sh_reg;  // Incoming byte
  logic [7:0] tx_sh_reg;  // Remaining bits of the outgoing byte
  logic [7:0] ptr_reg;  // Internal address pointer
  logic [1:0] idx_reg;  // Byte index within a write transfer
  logic ack_go_reg;  // Acknowledge the byte just received
  logic rw_reg;  // Read direction of this transfer
  logic more_reg;  // Controller acknowledged the last read byte
  logic sda_oe_reg, wr_stb_reg, flag_reg, hib_reg, snz_reg;
  gcp_wr_s wr_req_reg;

  logic rise_ev, fall_ev, start_ev, stop_ev;
  logic in_rx, byte_done, addr_hit, cmd_ok, data_ok, loc_ro;
  logic ack_slot, tx_load, mack_ack;
  logic [7:0] in_byte, tx_byte;

  // Link capture; its bit is read only once its toggle has crossed
  gcp_link_capture gcp_link_capture_inst (
    .i_scl_clk(i_scl),
    .i_link_rst(link_rst_reg),
    .i_sda(i_sda),
    .o_bit(cap_bit),
    .o_edge_tgl(cap_tgl)
  );

  // Registered copy of reset, glitch-free for the async link reset
  always_ff @(posedge i_clk_sys) begin
    link_rst_reg <= i_sys_rst;
  end

  // Two-stage synchronisers plus one delay stage for edge detection
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      {scl_s1_reg, scl_s2_reg, scl_d_reg} <= 3'h7;
      {sda_s1_reg, sda_s2_reg, sda_d_reg} <= 3'h7;
      {tgl_s1_reg, tgl_s2_reg, tgl_d_reg} <= 3'h0;
    end else begin
      {scl_s1_reg, scl_s2_reg, scl_d_reg} <= {i_scl, scl_s1_reg,
                                              scl_s2_reg};
      {sda_s1_reg, sda_s2_reg, sda_d_reg} <= {i_sda, sda_s1_reg,
                                              sda_s2_reg};
      {tgl_s1_reg, tgl_s2_reg, tgl_d_reg} <= {cap_tgl, tgl_s1_reg,
                                              tgl_s2_reg};
    end
  end

  // Bus events seen from the second synchroniser stage onward
  assign rise_ev = tgl_s2_reg ^ tgl_d_reg;
  assign fall_ev = scl_d_reg & ~scl_s2_reg;
  assign start_ev = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  assign stop_ev = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

  // Byte-level decisions
  assign in_rx = (st_reg == GCP_ST_ADDR) || (st_reg == GCP_ST_RX);
  assign in_byte = {sh_reg[6:0], cap_bit};
  assign byte_done = rise_ev && in_rx && (cnt_reg == GCP_LAST_BIT);
  assign addr_hit = byte_done && (st_reg == GCP_ST_ADDR) &&
                    (in_byte[7:1] == GCP_DEV_ADDR);
  assign cmd_ok = byte_done && (st_reg == GCP_ST_RX) &&
                  (idx_reg == GCP_IDX_CMD) &&
                  (in_byte <= GCP_CMD_TOP);
  // Status location is read-only whatever the core says
  assign loc_ro = i_loc_read_only ||
                  (ptr_reg == GCP_REG_LAST_PROFILE_STATUS);
  assign data_ok = byte_done && (st_reg == GCP_ST_RX) &&
                   (idx_reg == GCP_IDX_DATA) && !loc_ro;
  assign ack_slot = fall_ev && in_rx && (cnt_reg == GCP_BYTE_BITS);
  assign tx_load = fall_ev && (((st_reg == GCP_ST_ACK) && rw_reg) ||
                   ((st_reg == GCP_ST_MACK) && more_reg));
  assign mack_ack = rise_ev && (st_reg == GCP_ST_MACK) && !cap_bit;

  // Read data: status byte held here, past the top a filler byte
  always_comb begin
    if (ptr_reg == GCP_REG_LAST_PROFILE_STATUS) begin
      tx_byte = {GCP_STATUS_UNUSED, flag_reg};
    end else if (ptr_reg > GCP_CMD_TOP) begin
      tx_byte = GCP_IDLE_BYTE;
    end else begin
      tx_byte = i_rd_data;
    end
  end

  // Sequencer; a start always wins so a repeated start re-addresses
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_reg <= GCP_ST_IDLE;
      cnt_reg <= 4'h0;
    end else if (start_ev) begin
      st_reg <= GCP_ST_ADDR;
      cnt_reg <= 4'h0;
    end else if (stop_ev) begin
      st_reg <= GCP_ST_IDLE;
      cnt_reg <= 4'h0;
    end else begin
      unique case (st_reg)
        GCP_ST_IDLE, GCP_ST_WAIT: begin
          cnt_reg <= 4'h0;
        end
        GCP_ST_ADDR, GCP_ST_RX: begin
          if (rise_ev) begin
            cnt_reg <= cnt_reg + 4'h1;
          end else if (ack_slot) begin
            // Unmatched address or refused byte: let the line float
            st_reg <= ack_go_reg ? GCP_ST_ACK : GCP_ST_WAIT;
            cnt_reg <= 4'h0;
          end
        end
        GCP_ST_ACK: begin
          if (fall_ev) begin
            st_reg <= rw_reg ? GCP_ST_TX : GCP_ST_RX;
            cnt_reg <= rw_reg ? 4'h1 : 4'h0;
          end
        end
        GCP_ST_TX: begin
          if (fall_ev && (cnt_reg == GCP_BYTE_BITS)) begin
            st_reg <= GCP_ST_MACK;
            cnt_reg <= 4'h0;
          end else if (fall_ev) begin
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        GCP_ST_MACK: begin
          if (fall_ev) begin
            st_reg <= more_reg ? GCP_ST_TX : GCP_ST_WAIT;
            cnt_reg <= more_reg ? 4'h1 : 4'h0;
          end
        end
        default: begin
          st_reg <= GCP_ST_IDLE;
          cnt_reg <= 4'h0;
        end
      endcase
    end
  end

  // Receive shifter, direction, byte index and acknowledge decision
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || start_ev) begin
      sh_reg <= 8'h00;
      ack_go_reg <= 1'b0;
      idx_reg <= GCP_IDX_CMD;
      more_reg <= 1'b0;
      rw_reg <= i_sys_rst ? 1'b0 : rw_reg;
    end else begin
      if (rise_ev && in_rx) begin
        sh_reg <= in_byte;
      end
      if (byte_done) begin
        ack_go_reg <= addr_hit || cmd_ok || data_ok;
      end
      if (addr_hit) begin
        rw_reg <= in_byte[0];
      end
      if (byte_done && (st_reg == GCP_ST_RX) && (idx_reg != GCP_IDX_MAX)) begin
        idx_reg <= idx_reg + 2'h1;
      end
      if (rise_ev && (st_reg == GCP_ST_MACK)) begin
        more_reg <= !cap_bit;
      end
    end
  end

  // Address pointer: loaded by the command byte, bumped on each accepted data byte or controller ack
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ptr_reg <= 8'h00;
    end else if (cmd_ok) begin
      ptr_reg <= in_byte;
    end else if (data_ok || mack_ack) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // Data line driver: only ever pulls low, changes on falling clock
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || start_ev || stop_ev) begin
      sda_oe_reg <= 1'b0;
    end else if (fall_ev) begin
      if (ack_slot) begin
        sda_oe_reg <= ack_go_reg;
      end else if (tx_load) begin
        sda_oe_reg <= ~tx_byte[7];
      end else if ((st_reg == GCP_ST_TX) && (cnt_reg != GCP_BYTE_BITS)) begin
        sda_oe_reg <= ~tx_sh_reg[7];
      end else begin
        sda_oe_reg <= 1'b0;
      end
    end
  end

  // Outgoing byte shifter
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      tx_sh_reg <= 8'h00;
    end else if (tx_load) begin
      tx_sh_reg <= {tx_byte[6:0], 1'b0};
    end else if (fall_ev && (st_reg == GCP_ST_TX)) begin
      tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
    end
  end

  // Write request to the core, one pulse per accepted data byte
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wr_stb_reg <= 1'b0;
      wr_req_reg <= '0;
    end else begin
      wr_stb_reg <= data_ok;
      if (data_ok) begin
        wr_req_reg <= '{addr: ptr_reg, data: in_byte};
      end
    end
  end

  // Last-profile flag, updated by the core after profile selection
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      flag_reg <= GCP_LAST_PROFILE_RST;
    end else if (i_profile_upd) begin
      flag_reg <= i_profile_second;
    end
  end

  // Wake pulses: traffic for other targets never reaches addr_hit
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      hib_reg <= 1'b0;
      snz_reg <= 1'b0;
    end else begin
      hib_reg <= addr_hit && i_hibernate;
      snz_reg <= addr_hit && i_snooze;
    end
  end

  assign o_sda_o = 1'b0;
  assign o_sda_oe = sda_oe_reg;
  assign o_rd_addr = ptr_reg;
  assign o_wr_stb = wr_stb_reg;
  assign o_wr_req = wr_req_reg;
  assign o_last_profile_used_flag = flag_reg;
  assign o_hib_wake = hib_reg;
  assign o_snooze_exit = snz_reg;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  sequence s_cmd_byte;
    byte_done && (st_reg == GCP_ST_RX) && (idx_reg == GCP_IDX_CMD);
  endsequence
  sequence s_extra_byte;
    byte_done && (st_reg == GCP_ST_RX) && (idx_reg > GCP_IDX_DATA);
  endsequence

  a_foreign_addr: assert property (byte_done &&
    (st_reg == GCP_ST_ADDR) && (in_byte[7:1] != GCP_DEV_ADDR) |=> !ack_go_reg)
    else $error("foreign address acknowledged");
  a_read_dir: assert property (addr_hit && in_byte[0] |=>
    rw_reg && ack_go_reg)
    else $error("read address byte not taken as read");
  a_quick_read: assert property (fall_ev && rw_reg &&
    (st_reg == GCP_ST_ACK) |=> (sda_oe_reg == !$past(tx_byte[7])))
    else $error("read byte not taken from pointer");
  a_ptr_mack: assert property (mack_ack |=>
    (ptr_reg == $past(ptr_reg) + 8'h01))
    else $error("pointer did not advance on controller ack");
  a_ro_refused: assert property (byte_done && loc_ro &&
    (idx_reg == GCP_IDX_DATA) |=> !ack_go_reg && !wr_stb_reg)
    else $error("read-only location written");
  a_cmd_top: assert property (s_cmd_byte ##0
    (in_byte > GCP_CMD_TOP) |=> !ack_go_reg && $stable(ptr_reg))
    else $error("command above top acknowledged");
  a_extra_nack: assert property (s_extra_byte |=>
    !ack_go_reg && !wr_stb_reg)
    else $error("extra write byte acknowledged");
  a_status_read: assert property (tx_load &&
    (ptr_reg == GCP_REG_LAST_PROFILE_STATUS) |=> sda_oe_reg &&
    (tx_sh_reg[7:2] == 6'h00) && (tx_sh_reg[1] == $past(flag_reg)))
    else $error("status byte not built from the profile flag");
  a_flag_default: assert property ($fell(link_rst_reg) |->
    !flag_reg || $past(i_profile_upd))
    else $error("profile flag not cleared by reset");
  a_hib_wake: assert property (o_hib_wake |->
    $past(addr_hit) && $past(i_hibernate))
    else $error("wake without own address");
  a_ptr_load: assert property (s_cmd_byte ##0
    (in_byte <= GCP_CMD_TOP) |=> (ptr_reg == $past(in_byte)) && ack_go_reg)
    else $error("command byte did not load pointer");

endmodule

// ==== gcp_ctrl_model.sv ====
/*
  Behavioural I2C controller standing in for the system microcontroller.
  Assumes an open-drain data line with a pull-up resolved in the bench.
  The serial clock stands still outside frames.
*/
`timescale 1ns/100ps
module gcp_ctrl_model #(
  parameter int QUARTER_NS = 60  // Quarter of a 240 ns serial clock period
) (
  output logic o_scl,
  output logic o_sda_low,
  input wire logic i_sda
);
  // Both lines released at time zero
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // Start or repeated start, entered with the clock low or idle
  task automatic start_cond();
    o_sda_low = 1'b0;
    #(QUARTER_NS) o_scl = 1'b1;
    #(QUARTER_NS) o_sda_low = 1'b1;
    #(QUARTER_NS) o_scl = 1'b0;
    #(QUARTER_NS);
  endtask

  // Stop: data rises while the clock is high
  task automatic stop_cond();
    o_sda_low = 1'b1;
    #(QUARTER_NS) o_scl = 1'b1;
    #(QUARTER_NS) o_sda_low = 1'b0;
    #(QUARTER_NS);
  endtask

  // Send one byte MSB first, then sample the target's acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      o_sda_low = ~b[i];
      #(QUARTER_NS) o_scl = 1'b1;
      #(2 * QUARTER_NS) o_scl = 1'b0;
      #(QUARTER_NS);
    end
    // Release the line so the target can pull it for its acknowledge
    o_sda_low = 1'b0;
    #(QUARTER_NS) o_scl = 1'b1;
    #(QUARTER_NS) ack = (i_sda === 1'b0);
    #(QUARTER_NS) o_scl = 1'b0;
    #(QUARTER_NS);
  endtask

  // Receive one byte; an acknowledge asks for the next location
  task automatic recv_byte(input logic ack_it, output logic [7:0] b);
    o_sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #(QUARTER_NS) o_scl = 1'b1;
      #(QUARTER_NS) b[i] = i_sda;
      #(QUARTER_NS) o_scl = 1'b0;
      #(QUARTER_NS);
    end
    o_sda_low = ack_it;
    #(QUARTER_NS) o_scl = 1'b1;
    #(2 * QUARTER_NS) o_scl = 1'b0;
    // Held past the fall so the target's next bit meets a clean line
    #(QUARTER_NS) o_sda_low = 1'b0;
    // Let time pass so a following stop never re-drives in this step
    #(QUARTER_NS);
  endtask
endmodule

// ==== gcp_command_port_tb.sv ====
/*
  Self-checking bench for the gauge command port.
  Assumes the controller model above and a simple gauge core stand-in.
*/
`timescale 1ns/100ps
module gcp_command_port_tb;
  import gcp_pkg::*;
  logic clk_sys;
  logic sys_rst;
  logic scl;
  logic sda_low;  // Controller pulling the data line
  logic sda;
  logic sda_o;
  logic sda_oe;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic read_only;
  logic wr_stb;
  gcp_wr_s wr_req;
  gcp_wr_s last_wr;  // Last write handed to the core
  logic profile_upd;
  logic profile_second;
  logic flag;
  logic hibernate;
  logic snooze;
  logic hib_wake;
  logic snooze_exit;
  logic ack;
  logic [7:0] rx;
  int failures = 0;
  int check_count = 0;
  int wr_cnt = 0;
  int hib_cnt = 0;
  int snz_cnt = 0;

  // Open drain with pull-up: low whenever any party pulls
  assign sda = (sda_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
  // Core stand-in: a pattern everywhere, so the status byte must come
  // from the port itself and not from the core
  assign rd_data = rd_addr ^ 8'h3C;
  // One ordinary location is read-only for the refusal scenario
  assign read_only = (rd_addr == 8'h20);

  gcp_command_port gcp_command_port_inst (
    .i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_rd_addr(rd_addr),
    .i_rd_data(rd_data), .i_loc_read_only(read_only), .o_wr_stb(wr_stb),
    .o_wr_req(wr_req), .i_profile_upd(profile_upd),
    .i_profile_second(profile_second), .o_last_profile_used_flag(flag),
    .i_hibernate(hibernate), .i_snooze(snooze), .o_hib_wake(hib_wake),
    .o_snooze_exit(snooze_exit)
  );

  gcp_ctrl_model gcp_ctrl_model_inst (
    .o_scl(scl),
    .o_sda_low(sda_low),
    .i_sda(sda)
  );

  // Core clock, 4 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Count one-cycle pulses so none is missed between checks
  always @(posedge clk_sys) begin
    if (wr_stb === 1'b1) begin
      wr_cnt++;
      last_wr = wr_req;
    end
    if (hib_wake === 1'b1) hib_cnt++;
    if (snooze_exit === 1'b1) snz_cnt++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Byte to the target, comparing its acknowledge
  task automatic wr_b(input logic [7:0] b, input logic exp_ack);
    gcp_ctrl_model_inst.send_byte(b, ack);
    check({15'h0000, ack}, {15'h0000, exp_ack});
  endtask

  // Byte from the target, comparing its value
  task automatic rd_b(input logic ack_it, input logic [7:0] exp);
    gcp_ctrl_model_inst.recv_byte(ack_it, rx);
    check({8'h00, rx}, {8'h00, exp});
  endtask

  // Write 12 to 05, then an extra byte that must be refused
  task automatic t_write();
    gcp_ctrl_model_inst.start_cond();
    wr_b(GCP_ADDR_WR, 1'b1);
    wr_b(8'h05, 1'b1);
    wr_b(8'h12, 1'b1);
    wr_b(8'h34, 1'b0);
    gcp_ctrl_model_inst.stop_cond();
    cyc(8);
    check(16'(wr_cnt), 16'h0001);
    check(last_wr, 16'h0512);
    check({8'h00, rd_addr}, 16'h0006);
  endtask

  // Quick read continues from the pointer left by the write
  task automatic t_quick();
    gcp_ctrl_model_inst.start_cond();
    wr_b(GCP_ADDR_RD, 1'b1);
    rd_b(1'b1, 8'h06 ^ 8'h3C);
    rd_b(1'b0, 8'h07 ^ 8'h3C);
    gcp_ctrl_model_inst.stop_cond();
    cyc(8);
    check({8'h00, rd_addr}, 16'h0007);
  endtask

  // Status byte, incremental read across the top, read-only refusals
  task automatic t_status();
    @(posedge clk_sys);
    profile_second <= 1'b1;
    profile_upd <= 1'b1;
    @(posedge clk_sys);
    profile_upd <= 1'b0;
    cyc(2);
    check({15'h0000, flag}, 16'h0001);
    gcp_ctrl_model_inst.start_cond();
    wr_b(GCP_ADDR_WR, 1'b1);
    wr_b(GCP_REG_LAST_PROFILE_STATUS, 1'b1);
    gcp_ctrl_model_inst.start_cond();
    wr_b(GCP_ADDR_RD, 1'b1);
    rd_b(1'b1, 8'h01);
    rd_b(1'b1, GCP_CMD_TOP ^ 8'h3C);
    rd_b(1'b0, GCP_IDLE_BYTE);
    gcp_ctrl_model_inst.stop_cond();
    for (int i = 0; i < 2; i++) begin
      gcp_ctrl_model_inst.start_cond();
      wr_b(GCP_ADDR_WR, 1'b1);
      wr_b(i == 0 ? GCP_REG_LAST_PROFILE_STATUS : 8'h20, 1'b1);
      wr_b(8'h55, 1'b0);
      gcp_ctrl_model_inst.stop_cond();
    end
    cyc(8);
    check(16'(wr_cnt), 16'h0001);
    check({15'h0000, flag}, 16'h0001);
  endtask

  // Command bytes on each side of the top location
  task automatic t_limits();
    gcp_ctrl_model_inst.start_cond();
    wr_b(GCP_ADDR_WR, 1'b1);
    wr_b(GCP_CMD_TOP + 8'h01, 1'b0);
    gcp_ctrl_model_inst.stop_cond();
    gcp_ctrl_model_inst.start_cond();
    wr_b(GCP_ADDR_WR, 1'b1);
    wr_b(GCP_CMD_TOP, 1'b1);
    gcp_ctrl_model_inst.stop_cond();
  endtask

  // Foreign traffic must not wake; own address must
  task automatic t_wake();
    @(posedge clk_sys);
    hibernate <= 1'b1;
    gcp_ctrl_model_inst.start_cond();
    wr_b(8'hA8, 1'b0);
    gcp_ctrl_model_inst.stop_cond();
    cyc(8);
    check(16'(hib_cnt), 16'h0000);
    gcp_ctrl_model_inst.start_cond();
    wr_b(GCP_ADDR_WR, 1'b1);
    gcp_ctrl_model_inst.stop_cond();
    cyc(8);
    check(16'(hib_cnt), 16'h0001);
    hibernate <= 1'b0;
    snooze <= 1'b1;
    gcp_ctrl_model_inst.start_cond();
    wr_b(GCP_ADDR_RD, 1'b1);
    rd_b(1'b0, GCP_CMD_TOP ^ 8'h3C);
    gcp_ctrl_model_inst.stop_cond();
    cyc(8);
    check(16'(snz_cnt), 16'h0001);
    check(16'(hib_cnt), 16'h0001);
  endtask

  // Hang guard: a run this long counts as a mismatch
  initial begin
    #200000;
    check(16'h0000, 16'h0001);
    report_and_stop();
  end

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    profile_upd = 1'b0;
    profile_second = 1'b0;
    hibernate = 1'b0;
    snooze = 1'b0;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    cyc(4);
    check({15'h0000, sda_oe}, 16'h0000);
    check({8'h00, rd_addr}, 16'h0000);
    check({15'h0000, flag}, 16'h0000);
    t_write();
    t_quick();
    t_status();
    t_limits();
    t_wake();
    report_and_stop();
  end
endmodule
